// File: logic/sct_map.svh
// Register offsets, field positions, reset values and timing counts of the touch sequencer
`ifndef SCT_MAP_SVH
`define SCT_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define SCT_ADDR_CFG      16'hA150
`define SCT_ADDR_ANA      16'hA151
`define SCT_ADDR_CMD      16'hA152
`define SCT_ADDR_CNTL     16'hA153
`define SCT_ADDR_CNTH     16'hA154
`define SCT_ADDR_STAT     16'hA155
`define SCT_ADDR_MASK     16'hA156
`define SCT_ADDR_DIV      16'hA157

// ****************************************
// Field positions
// ****************************************
`define SCT_CFG_EN        7
`define SCT_CFG_PSR       6
`define SCT_CFG_REF       5
`define SCT_CFG_VTH       4
`define SCT_ANA_PD        7
`define SCT_CMD_INTEN     7
`define SCT_CMD_AUTO_SHIFT    4
`define SCT_CMD_COMPLETION_FLAG      1
`define SCT_CMD_START     0
`define SCT_STAT_DONE     0
`define SCT_STAT_CONV     1
`define SCT_STAT_ABORT    2

// ****************************************
// Reset values
// ****************************************
`define SCT_RST_CFG       8'h00
`define SCT_RST_ANA       8'h00
`define SCT_RST_MASK      3'h1
`define SCT_RST_DIV       2'h0

// ****************************************
// Timing counts in system clock periods
// ****************************************
`define SCT_ZERO_HEAD     4
`define SCT_ZERO_STEP     128
`define SCT_ZERO_TAIL     1
`define SCT_PD_STEP       128

`endif

// File: logic/sct_pkg.sv
// Types shared by the touch sequencer and its comparator filter
package sct_pkg;

    typedef enum logic [3:0] {
        SCT_IDLE   = 4'h1,
        SCT_ZERO   = 4'h2,
        SCT_CHARGE = 4'h4,
        SCT_DUMP   = 4'h8
    } sct_state_e;

    typedef logic [17:0] sct_count_t;

    typedef struct packed {
        logic [3:0] run;
        logic       out;
    } sct_filt_s;

    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  ana;
        logic        inten;
        logic        auto_shift;
        logic [1:0]  rpt;
        logic        start;
        logic [2:0]  stat;
        logic [2:0]  mask;
        logic [1:0]  div_sel;
        logic [2:0]  div_cnt;
        logic        tick;
        sct_state_e  state;
        logic [10:0] timer;
        logic [3:0]  conv_n;
        sct_count_t  count;
        logic [7:0]  rdata;
        logic        irq;
        logic        gnd_sw;
        logic        pd_on;
        logic        chg_sw;
        logic        dmp_sw;
        logic        sync1;
        logic        sync2;
    } sct_regs_s;

endpackage

// File: logic/sct_cmp_filter.sv
// Comparator run-length filter sampled on the system clock enable
module sct_cmp_filter (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Sampling
    input  wire logic       sample_en,
    input  wire logic       raw,
    input  wire logic [3:0] len,
    // Result
    output logic            filt
);
    import sct_pkg::*;

    sct_filt_s q, d;
    logic [3:0] need;

    always_comb begin
        d = q;
        // A zero length would always hold; treat it as a single sample
        need = (len == 4'h0) ? 4'h1 : len;
        if (sample_en) begin
            if (raw) begin
                if (q.run != 4'hF) begin
                    d.run = q.run + 4'h1;
                end
                d.out = (d.run >= need);
            end else begin
                d.run = 4'h0;
                d.out = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign filt = q.out;

    a_filt_needs_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(q.out) |-> $past(raw) && $past(sample_en))
        else $error("filter rose without a one sample");

endmodule

// File: logic/sct_touch_seq.sv
// Switched-capacitance touch key sequencer with register port and interrupt
//
// Added by the designer: strobed register access.
`include "sct_map.svh"

module sct_touch_seq (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [7:0]       rd_data,
    // Analog side
    input  wire logic        comp_raw,
    output logic             ref_ground_sw,
    output logic             pad_pulldown_on,
    output logic             charge_sw,
    output logic             dump_sw,
    output logic             threshold_select,
    output logic             reference_select,
    // Status
    output logic             busy,
    output logic             irq
);
    import sct_pkg::*;

    sct_regs_s q, d;
    logic       filt;
    logic       en;
    logic [3:0] cdt;
    logic [2:0] zero_f;
    logic [10:0] zlen;
    logic [10:0] pdlen;
    logic [2:0] div_lim;
    logic [3:0] conv_total;
    sct_count_t cnt_inc;
    logic       ev_done;
    logic       ev_conv;
    logic       ev_abort;

    // ****************************************
    // Field decode
    // ****************************************
    assign en         = q.cfg[`SCT_CFG_EN];
    assign cdt        = q.cfg[3:0];
    assign zero_f     = q.ana[6:4];
    assign zlen       = 11'(`SCT_ZERO_HEAD + `SCT_ZERO_STEP * (int'(zero_f) + 1) + `SCT_ZERO_TAIL);
    assign pdlen      = 11'(`SCT_PD_STEP * int'(zero_f));
    assign div_lim    = 3'((4'h1 << q.div_sel) - 4'h1);
    assign conv_total = 4'(5'h1 << q.rpt);
    assign cnt_inc    = (q.count == '1) ? q.count : q.count + 18'h1;

    sct_cmp_filter u_filt (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .sample_en (q.tick),
        .raw       (q.sync2),
        .len       (q.ana[3:0]),
        .filt      (filt)
    );

    always_comb begin
        d        = q;
        ev_done  = 1'b0;
        ev_conv  = 1'b0;
        ev_abort = 1'b0;
        d.rdata  = 8'h00;
        d.sync1  = comp_raw;
        d.sync2  = q.sync1;

        // ****************************************
        // System clock enable divider
        // ****************************************
        // One clock domain only: slower rates are enable pulses, not clocks
        if (q.div_cnt >= div_lim) begin
            d.div_cnt = 3'h0;
            d.tick    = 1'b1;
        end else begin
            d.div_cnt = q.div_cnt + 3'h1;
            d.tick    = 1'b0;
        end

        // ****************************************
        // Register writes
        // ****************************************
        if (wr_en) begin
            unique case (addr)
                `SCT_ADDR_CFG: d.cfg = wr_data;
                `SCT_ADDR_ANA: d.ana = wr_data;
                `SCT_ADDR_CMD: begin
                    d.inten = wr_data[`SCT_CMD_INTEN];
                    // Repeat setup is frozen mid run so the accumulation stays consistent
                    if (!q.start) begin
                        d.auto_shift = wr_data[`SCT_CMD_AUTO_SHIFT];
                        d.rpt    = wr_data[3:2];
                    end
                    if (wr_data[`SCT_CMD_COMPLETION_FLAG]) begin
                        d.stat[`SCT_STAT_DONE] = 1'b0;
                    end
                    if (wr_data[`SCT_CMD_START] && en && !q.start) begin
                        d.start  = 1'b1;
                        d.count  = '0;
                        d.conv_n = 4'h0;
                    end
                end
                `SCT_ADDR_CNTL: begin
                    if (!q.start) begin
                        d.count[7:0] = wr_data;
                    end
                end
                `SCT_ADDR_CNTH: begin
                    if (!q.start) begin
                        d.count[15:8] = wr_data;
                    end
                end
                `SCT_ADDR_STAT: d.stat = q.stat & ~wr_data[2:0];
                `SCT_ADDR_MASK: d.mask = wr_data[2:0];
                `SCT_ADDR_DIV:  d.div_sel = wr_data[1:0];
                default: ;
            endcase
        end

        // ****************************************
        // Measurement sequencer
        // ****************************************
        if (!en && (q.state != SCT_IDLE || q.start)) begin
            // Dropping the enable abandons the run; the partial count stays readable
            // A start still waiting for its first tick is dropped too, so nothing runs disabled
            d.state  = SCT_IDLE;
            d.start  = 1'b0;
            d.gnd_sw = 1'b0;
            d.pd_on  = 1'b0;
            d.chg_sw = 1'b0;
            d.dmp_sw = 1'b0;
            ev_abort = 1'b1;
        end else if (q.tick) begin
            unique case (q.state)
                SCT_IDLE: begin
                    if (q.start) begin
                        d.state  = SCT_ZERO;
                        d.timer  = 11'h0;
                        d.gnd_sw = 1'b1;
                        d.pd_on  = q.ana[`SCT_ANA_PD] && (pdlen != 11'h0);
                    end
                end
                SCT_ZERO: begin
                    d.timer = q.timer + 11'h1;
                    if (q.timer + 11'h1 >= pdlen) begin
                        d.pd_on = 1'b0;
                    end
                    // Compare with >= so a length shortened mid-run cannot be stepped over
                    if (q.timer >= zlen - 11'h1) begin
                        d.state  = SCT_CHARGE;
                        d.timer  = 11'h0;
                        d.gnd_sw = 1'b0;
                        d.pd_on  = 1'b0;
                        d.chg_sw = 1'b1;
                    end
                end
                SCT_CHARGE: begin
                    d.timer = q.timer + 11'h1;
                    if (q.timer >= 11'(cdt)) begin
                        d.state  = SCT_DUMP;
                        d.timer  = 11'h0;
                        d.chg_sw = 1'b0;
                        d.dmp_sw = 1'b1;
                    end
                end
                SCT_DUMP: begin
                    d.timer = q.timer + 11'h1;
                    if (q.timer >= 11'(cdt)) begin
                        d.timer  = 11'h0;
                        d.dmp_sw = 1'b0;
                        d.count  = cnt_inc;
                        if (filt) begin
                            // Threshold reached: this conversion is over
                            d.conv_n = q.conv_n + 4'h1;
                            ev_conv  = 1'b1;
                            if (q.conv_n + 4'h1 == conv_total) begin
                                d.state = SCT_IDLE;
                                d.start = 1'b0;
                                if (q.auto_shift) begin
                                    d.count = cnt_inc >> q.rpt;
                                end
                                ev_done = 1'b1;
                            end else begin
                                // Each repeated conversion starts from an empty reference
                                d.state  = SCT_ZERO;
                                d.gnd_sw = 1'b1;
                                d.pd_on  = q.ana[`SCT_ANA_PD] && (pdlen != 11'h0);
                            end
                        end else begin
                            d.state  = SCT_CHARGE;
                            d.chg_sw = 1'b1;
                        end
                    end
                end
                default: begin
                    d.state = SCT_IDLE;
                end
            endcase
        end

        // ****************************************
        // Events and interrupt
        // ****************************************
        // Events are applied after the clears so a same-cycle set is never lost
        if (ev_done) begin
            d.stat[`SCT_STAT_DONE] = 1'b1;
        end
        if (ev_conv) begin
            d.stat[`SCT_STAT_CONV] = 1'b1;
        end
        if (ev_abort) begin
            d.stat[`SCT_STAT_ABORT] = 1'b1;
        end
        d.irq = (d.stat[`SCT_STAT_DONE] && d.inten && d.mask[`SCT_STAT_DONE]) ||
                (|(d.stat[2:1] & d.mask[2:1]));

        // ****************************************
        // Register reads
        // ****************************************
        if (rd_en) begin
            unique case (addr)
                `SCT_ADDR_CFG:  d.rdata = q.cfg;
                `SCT_ADDR_ANA:  d.rdata = q.ana;
                `SCT_ADDR_CMD:  d.rdata = {q.inten, q.count[17:16], q.auto_shift, q.rpt,
                                           q.stat[`SCT_STAT_DONE], q.start};
                `SCT_ADDR_CNTL: d.rdata = q.count[7:0];
                `SCT_ADDR_CNTH: d.rdata = q.count[15:8];
                `SCT_ADDR_STAT: d.rdata = {5'h00, q.stat};
                `SCT_ADDR_MASK: d.rdata = {5'h00, q.mask};
                `SCT_ADDR_DIV:  d.rdata = {6'h00, q.div_sel};
                default:        d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q         <= '0;
            q.cfg     <= `SCT_RST_CFG;
            q.ana     <= `SCT_RST_ANA;
            q.mask    <= `SCT_RST_MASK;
            q.div_sel <= `SCT_RST_DIV;
            q.state   <= SCT_IDLE;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rd_data          = q.rdata;
    assign ref_ground_sw    = q.gnd_sw;
    assign pad_pulldown_on  = q.pd_on;
    assign charge_sw        = q.chg_sw;
    assign dump_sw          = q.dmp_sw;
    assign threshold_select = q.cfg[`SCT_CFG_VTH];
    assign reference_select = q.cfg[`SCT_CFG_REF];
    assign busy             = q.start;
    assign irq              = q.irq;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_last_dump;
        q.state == SCT_DUMP && q.tick && en && q.timer == 11'(cdt) && filt && q.conv_n + 4'h1 == conv_total;
    endsequence

    a_ground_open: assert property ((q.state == SCT_CHARGE || q.state == SCT_DUMP) |-> !q.gnd_sw)
        else $error("ground switch closed during charge transfer");
    a_zero_exit: assert property (q.state == SCT_ZERO && q.tick && en && q.timer == zlen - 11'h1
        |=> q.state == SCT_CHARGE && q.chg_sw && !q.gnd_sw)
        else $error("discharge did not end on time");
    a_zero_bound: assert property (q.state == SCT_ZERO |-> q.timer < zlen && q.gnd_sw)
        else $error("discharge overran its length");
    a_pulldown_gate: assert property (q.pd_on |-> q.ana[`SCT_ANA_PD] && q.state == SCT_ZERO && q.timer < pdlen)
        else $error("pad pulldown outside its window");
    a_charge_length: assert property (q.state == SCT_CHARGE |-> q.timer <= 11'(cdt) && q.chg_sw)
        else $error("charge phase overran");
    a_count_step: assert property (q.state == SCT_DUMP && q.tick && en && q.timer == 11'(cdt)
        && !q.auto_shift && q.count != '1 |=> q.count == $past(q.count) + 18'h1)
        else $error("dump did not count one cycle");
    a_done_flag: assert property (s_last_dump |=> q.stat[`SCT_STAT_DONE] && !q.start && q.state == SCT_IDLE)
        else $error("completion did not set flag and clear start");
    a_irq_raise: assert property ($rose(q.stat[`SCT_STAT_DONE]) && q.inten && q.mask[0] |-> q.irq)
        else $error("enabled completion raised no interrupt");
    a_enable_abort: assert property (!en && q.state != SCT_IDLE |=> q.state == SCT_IDLE && !q.start)
        else $error("sequence kept running while disabled");
    a_busy_track: assert property (q.state != SCT_IDLE |-> q.start)
        else $error("sequencer active without busy");
    a_count_clear: assert property (wr_en && addr == `SCT_ADDR_CMD && wr_data[0] && en && !q.start
        |=> q.count == '0 && q.start)
        else $error("start did not clear the count");
    a_repeat_cap: assert property (q.start |-> q.conv_n < conv_total)
        else $error("more conversions than the repeat field allows");
    a_tick_divide: assert property (q.tick && q.div_sel != 2'h0 && !(wr_en && addr == `SCT_ADDR_DIV)
        |=> !q.tick)
        else $error("divided enable fired on consecutive clocks");

    // Start seen on a tick: the discharge opens with the ground switch closed
    sequence s_start_tick;
        q.state == SCT_IDLE && q.start && q.tick && en;
    endsequence

    a_start_ground: assert property (s_start_tick |=> q.state == SCT_ZERO && q.gnd_sw && q.timer == 11'h0)
        else $error("start did not close the ground switch");
    a_start_pulldown: assert property (s_start_tick ##0 q.ana[`SCT_ANA_PD] && pdlen != 11'h0 |=> q.pd_on)
        else $error("pad pulldown missing at discharge start");
    a_dump_length: assert property (q.state == SCT_DUMP |-> q.timer <= 11'(cdt) && q.dmp_sw)
        else $error("dump phase overran");
    a_flag_sticky: assert property (q.stat[`SCT_STAT_DONE]
        && !(wr_en && addr == `SCT_ADDR_CMD && wr_data[`SCT_CMD_COMPLETION_FLAG])
        && !(wr_en && addr == `SCT_ADDR_STAT && wr_data[`SCT_STAT_DONE])
        |=> q.stat[`SCT_STAT_DONE])
        else $error("completion flag dropped without a software clear");
    a_start_refused: assert property (wr_en && addr == `SCT_ADDR_CMD && wr_data[`SCT_CMD_START] && !en
        && !q.start |=> !q.start)
        else $error("start accepted while disabled");

endmodule

// File: sim/sct_analog_model.sv
// Behavioural reference capacitor, sense capacitor and comparator facing the sequencer
module sct_analog_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Switches driven by the sequencer
    input  wire logic       ref_ground_sw,
    input  wire logic       dump_sw,
    // Dumps needed before the reference capacitor crosses the threshold
    input  wire logic [7:0] dumps_to_cross,
    // Comparator
    output logic            comp_raw
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] dumps_q;
    logic       dump_q;

    // Grounding empties the reference capacitor; each new dump adds one charge step
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dumps_q <= 8'h00;
            dump_q  <= 1'b0;
        end else begin
            dump_q <= dump_sw;
            if (ref_ground_sw) begin
                dumps_q <= 8'h00;
            end else if (dump_sw && !dump_q && dumps_q != 8'hFF) begin
                dumps_q <= dumps_q + 8'h01;
            end
        end
    end

    // Crossing shows while charge is transferred, so a filter of up to four samples settles inside that dump
    assign comp_raw = (dumps_q >= dumps_to_cross) && !ref_ground_sw;
endmodule

// File: sim/sct_touch_seq_tb.sv
// Self-checking bench for the touch sequencer register port and measurement sequence
`include "sct_map.svh"

module sct_touch_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk;
    logic        rst_n;
    logic [15:0] addr;
    logic [7:0]  wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rd_data;
    logic        comp_raw;
    logic        ref_ground_sw;
    logic        pad_pulldown_on;
    logic        charge_sw;
    logic        dump_sw;
    logic        threshold_select;
    logic        reference_select;
    logic        busy;
    logic        irq;
    logic [7:0]  dumps_to_cross;
    logic [7:0]  v;
    int          n;
    int          err_count;
    int          n_tests;
    int          cycles = 0;

    sct_touch_seq u_sct_touch_seq (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .comp_raw(comp_raw), .ref_ground_sw(ref_ground_sw),
        .pad_pulldown_on(pad_pulldown_on), .charge_sw(charge_sw), .dump_sw(dump_sw),
        .threshold_select(threshold_select), .reference_select(reference_select), .busy(busy), .irq(irq));

    sct_analog_model u_sct_analog_model (.ref_clk(ref_clk), .rst_n(rst_n), .ref_ground_sw(ref_ground_sw),
        .dump_sw(dump_sw), .dumps_to_cross(dumps_to_cross), .comp_raw(comp_raw));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Whole run needs a few thousand cycles; the ceiling leaves ample margin
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    // ****************************************
    // Access and check tasks
    // ****************************************
    task automatic wrap_up();
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t ns: seen 0x%0h expected 0x%0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return ref_ground_sw;
            1: return pad_pulldown_on;
            2: return charge_sw;
            default: return dump_sw;
        endcase
    endfunction

    // Width in clocks of the next high pulse; both edges are seen at clock edges
    task automatic width(input int s, output int w);
        int i;
        w = 0;
        i = 0;
        // Test before waiting: the pulse may already have begun at the call
        while (sig(s) !== 1'b1 && i < 400) begin
            @(posedge ref_clk);
            i++;
        end
        while (sig(s) === 1'b1 && w < 5000) begin
            @(posedge ref_clk);
            w++;
        end
    endtask

    task automatic wait_idle();
        int i;
        repeat (3) @(posedge ref_clk);
        for (i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge ref_clk);
        settle();
        chk(busy, 1'b0);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        rst_n = 1'b0;
        addr = 16'h0000;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        dumps_to_cross = 8'h03;
        err_count = 0;
        n_tests = 0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 5; a++) rd_chk(16'hA150 + 16'(a), 8'h00);
        rd_chk(`SCT_ADDR_MASK, 8'h01);
        rd_chk(16'hA158, 8'h00);
        wr(`SCT_ADDR_CMD, 8'h01);
        settle();
        chk(busy, 1'b0);
        wr(`SCT_ADDR_CFG, 8'hF7);
        wr(`SCT_ADDR_ANA, 8'h01);
        rd_chk(`SCT_ADDR_CFG, 8'hF7);
        chk(threshold_select, 1'b1);
        chk(reference_select, 1'b1);
        wr(`SCT_ADDR_CFG, 8'h87);
        settle();
        chk(threshold_select, 1'b0);
        chk(reference_select, 1'b0);
        // One conversion with phase timing and interrupt
        wr(`SCT_ADDR_CMD, 8'h81);
        width(0, n);
        chk(n, 133);
        width(2, n);
        chk(n, 8);
        width(3, n);
        chk(n, 8);
        wait_idle();
        chk(irq, 1'b1);
        rd_chk(`SCT_ADDR_CNTL, 8'h03);
        rd_chk(`SCT_ADDR_CMD, 8'h82);
        wr(`SCT_ADDR_MASK, 8'h00);
        settle();
        chk(irq, 1'b0);
        wr(`SCT_ADDR_MASK, 8'h01);
        settle();
        chk(irq, 1'b1);
        wr(`SCT_ADDR_CMD, 8'h02);
        settle();
        chk(irq, 1'b0);
        rd_chk(`SCT_ADDR_CMD, 8'h00);
        wr(`SCT_ADDR_CNTH, 8'h5A);
        rd_chk(`SCT_ADDR_CNTH, 8'h5A);
        // Every repeat code, count cleared at start and accumulated
        for (int r = 0; r < 4; r++) begin
            wr(`SCT_ADDR_CMD, {4'h0, r[1:0], 2'b01});
            settle();
            chk(busy, 1'b1);
            rd_chk(`SCT_ADDR_CNTL, 8'h00);
            wait_idle();
            rd_chk(`SCT_ADDR_CNTL, 8'(3 << r));
            rd_chk(`SCT_ADDR_CNTH, 8'h00);
        end
        // Automatic shift halves a two-conversion total back to one
        wr(`SCT_ADDR_CMD, 8'h15);
        wait_idle();
        rd_chk(`SCT_ADDR_CNTL, 8'h03);
        // Eight-sample filter misses the third dump and ends on the fourth
        wr(`SCT_ADDR_ANA, 8'h08);
        wr(`SCT_ADDR_CMD, 8'h01);
        wait_idle();
        rd_chk(`SCT_ADDR_CNTL, 8'h04);
        // Pad pulldown over two zero steps
        wr(`SCT_ADDR_ANA, 8'hA1);
        wr(`SCT_ADDR_CMD, 8'h01);
        width(1, n);
        chk(n, 256);
        wait_idle();
        // Divided sequencer clock doubles the discharge
        wr(`SCT_ADDR_ANA, 8'h01);
        wr(`SCT_ADDR_DIV, 8'h01);
        wr(`SCT_ADDR_CMD, 8'h01);
        width(0, n);
        chk(n, 266);
        wait_idle();
        wr(`SCT_ADDR_DIV, 8'h00);
        // Enable dropped in mid-discharge
        wr(`SCT_ADDR_STAT, 8'h07);
        wr(`SCT_ADDR_ANA, 8'h71);
        wr(`SCT_ADDR_CMD, 8'h01);
        repeat (20) @(posedge ref_clk);
        wr(`SCT_ADDR_CFG, 8'h07);
        settle();
        chk(busy, 1'b0);
        chk(ref_ground_sw, 1'b0);
        rd(`SCT_ADDR_STAT, v);
        chk(v[2], 1'b1);
        wr(`SCT_ADDR_MASK, 8'h04);
        settle();
        chk(irq, 1'b1);
        wr(`SCT_ADDR_STAT, 8'h04);
        settle();
        chk(irq, 1'b0);
        wrap_up();
    end
endmodule
